//--- mfg_cfg.svh
// constants for the multi-function interrupt group
`ifndef MFG_CFG_SVH
`define MFG_CFG_SVH

// =====================================================================
// sizes
`define MFG_NUM_GROUPS     4
`define MFG_NUM_TIMERS     3
`define MFG_FIXED_SOURCES  3

// =====================================================================
// source positions in the flag vector
`define MFG_SRC_SERIAL     0
`define MFG_SRC_LOWV       1
`define MFG_SRC_EEPROM     2
`define MFG_SRC_TIMER_BASE 3
`define MFG_MAP_BITS       2

// =====================================================================
// reset values and default group map, two bits per source
`define MFG_GIE_RESET      1'h0
`define MFG_FLAG_RESET     1'h0
`define MFG_MAP_DEFAULT    18'h2_943F

`endif

//--- mfg_pkg.sv
// types shared by the multi-function interrupt group modules
package mfg_pkg;
    typedef logic [1:0] grp_t;
    typedef enum logic {ST_RUN, ST_CALL} seq_e;
endpackage

//--- mfg_src_if.sv
// bundle between the group controller and the source flag store
`timescale 1ns/1ns
interface mfg_src_if #(parameter int N = 9);
    logic [N-1:0] set_evt;
    logic [N-1:0] sw_set;
    logic [N-1:0] sw_clr;
    logic [N-1:0] flag;
    logic [N-1:0] rise;
    modport store (input set_evt, input sw_set, input sw_clr,
                   output flag, output rise);
    modport ctrl  (output set_evt, output sw_set, output sw_clr,
                   input flag, input rise);
endinterface

//--- mfg_source_flags.sv
// per-source request flags with rising-edge report
`timescale 1ns/1ns
`include "mfg_cfg.svh"
module mfg_source_flags import mfg_pkg::*; #(
    parameter int N = 9
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    mfg_src_if.store    src
);
    logic [N-1:0] flag_r;
    logic [N-1:0] prev_r;

    // =================================================================
    // flag storage: a hardware set wins over a software clear
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_r[i] <= `MFG_FLAG_RESET;
                end else if (src.set_evt[i] || src.sw_set[i]) begin
                    flag_r[i] <= 1'h1;
                end else if (src.sw_clr[i]) begin
                    flag_r[i] <= 1'h0; // RULE14
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= {N{`MFG_FLAG_RESET}};
        end else begin
            prev_r <= flag_r;
        end
    end

    assign src.flag = flag_r;
    // a flag already high cannot rise, so software can pre-set it
    assign src.rise = flag_r & ~prev_r; // RULE11 RULE13

    // =================================================================
    // checks
    a_flag_only_sw_clear: assert property ( // RULE14
        @(posedge clk) disable iff (!rst_n)
        (|(~flag_r & prev_r)) |-> $past(|src.sw_clr))
        else $error("request flag dropped without software clear");
    a_event_sets_flag: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_n)
        (|src.set_evt) |=> ((flag_r & $past(src.set_evt))
                            == $past(src.set_evt)))
        else $error("source event did not set its flag");
endmodule

//--- multifunction_interrupt_group.sv
// multi-function interrupt group: flags, gating, vector call, wake-up
// =====================================================================
// What this block does
// RULE1 - serial byte done, address match or bus time-out sets serial flag
// RULE2 - serial request vectors only with global, serial, group enables, stack free
// RULE3 - serial service clears global enable and group flag, keeps serial flag
// RULE4 - low supply sets low-voltage flag; vectors with all enables, stack free
// RULE5 - low-voltage service clears global enable and group flag only
// RULE6 - finished eeprom write sets its flag; vectors with all enables set
// RULE7 - eeprom service clears global enable and group flag only
// RULE8 - each timer has match A and match P flags and enables
// RULE9 - timer request vectors with global, timer, group enables, stack free
// RULE10 - timer service clears global enable and its group flag only
// RULE11 - any request flag rising from low to high raises a wake-up
// RULE12 - wake-up ignores every enable bit
// RULE13 - software pre-sets a flag before sleep to mute its wake-up
// RULE14 - a set flag holds until cleared by software, service keeps it
// RULE15 - interrupt entry pushes only the program counter
// RULE16 - interrupt exit pops return address and sets global enable
// RULE17 - subroutine exit pops return address, global enable stays low
// RULE18 - a group flag sets when any enabled member source request newly appears
// RULE19 - source to group mapping is a design parameter
`timescale 1ns/1ns
`include "mfg_cfg.svh"
module multifunction_interrupt_group import mfg_pkg::*; #(
    parameter int NTM  = `MFG_NUM_TIMERS,
    parameter int NSRC = `MFG_FIXED_SOURCES + 2 * NTM,
    parameter logic [`MFG_MAP_BITS*NSRC-1:0] SRC_GROUP_MAP =
        `MFG_MAP_DEFAULT
) (
    input  wire logic                      REF_CLK,
    input  wire logic                      RST_N,
    input  wire logic                      SERIAL_BYTE_DONE,
    input  wire logic                      SERIAL_ADDR_MATCH,
    input  wire logic                      SERIAL_BUS_TIMEOUT,
    input  wire logic                      LOW_VOLTAGE_DETECT,
    input  wire logic                      EEPROM_WRITE_DONE,
    input  wire logic [NTM-1:0]            TIMER_MATCH_A,
    input  wire logic [NTM-1:0]            TIMER_MATCH_P,
    input  wire logic [NSRC-1:0]           FLAG_SET,
    input  wire logic [NSRC-1:0]           FLAG_CLEAR,
    input  wire logic                      SERIAL_MODULE_ENABLE,
    input  wire logic                      LOW_VOLTAGE_ENABLE,
    input  wire logic                      EEPROM_WRITE_ENABLE,
    input  wire logic [NTM-1:0]            TIMER_ENABLE_A,
    input  wire logic [NTM-1:0]            TIMER_ENABLE_P,
    input  wire logic [`MFG_NUM_GROUPS-1:0] GROUP_ENABLE,
    input  wire logic                      GLOBAL_ENABLE_SET,
    input  wire logic                      GLOBAL_ENABLE_CLEAR,
    input  wire logic                      STACK_FULL,
    input  wire logic                      INTERRUPT_EXIT,
    input  wire logic                      SUBROUTINE_EXIT,
    output wire logic                      VECTOR_CALL,
    output wire grp_t                      VECTOR_GROUP,
    output wire logic                      PC_PUSH,
    output wire logic                      PC_POP,
    output wire logic                      GLOBAL_IRQ_ENABLE,
    output wire logic [NSRC-1:0]           SOURCE_FLAGS,
    output wire logic [`MFG_NUM_GROUPS-1:0] GROUP_FLAGS,
    output wire logic                      WAKEUP
);
    localparam int NG = `MFG_NUM_GROUPS;

    mfg_src_if #(.N(NSRC)) src ();

    seq_e                state_r;
    logic                call_r;
    grp_t                group_r;
    logic                pop_r;
    logic                gie_r;
    logic                wake_r;
    logic [NG-1:0]       group_flag_r;
    logic [NSRC-1:0]     pend_q_r;
    logic [NSRC-1:0]     en_vec;
    logic [NSRC-1:0]     pend;
    logic [NSRC-1:0]     pend_rise;
    logic [NG-1:0]       group_set;
    logic [NG-1:0]       group_req;
    logic                req_any;
    logic                lv_s1_r;
    logic                lv_s2_r;
    logic                lv_s3_r;
    logic                lv_level_r;
    logic                lv_prev_r;
    logic                lv_rise;

    // =================================================================
    // decode helpers
    function automatic logic in_group(input int unsigned s,
                                      input int unsigned g);
        return SRC_GROUP_MAP[`MFG_MAP_BITS*s +: `MFG_MAP_BITS]
               == grp_t'(g); // RULE19
    endfunction

    function automatic grp_t pick(input logic [NG-1:0] r);
        grp_t p;
        p = grp_t'(0);
        // lowest group number has priority
        for (int g = NG - 1; g >= 0; g--) begin
            if (r[g]) begin
                p = grp_t'(g);
            end
        end
        return p;
    endfunction

    // =================================================================
    // low supply detector output is asynchronous to the clock
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lv_s1_r <= 1'h0;
            lv_s2_r <= 1'h0;
            lv_s3_r <= 1'h0;
        end else begin
            lv_s1_r <= LOW_VOLTAGE_DETECT;
            lv_s2_r <= lv_s1_r;
            lv_s3_r <= lv_s2_r;
        end
    end

    // a change counts only once two stages agree, which filters glitches
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lv_level_r <= 1'h0;
            lv_prev_r  <= 1'h0;
        end else begin
            if (lv_s2_r == lv_s3_r) begin
                lv_level_r <= lv_s3_r;
            end
            lv_prev_r <= lv_level_r;
        end
    end

    assign lv_rise = lv_level_r & ~lv_prev_r;

    // =================================================================
    // source events and enables
    assign src.set_evt[`MFG_SRC_SERIAL] = SERIAL_BYTE_DONE
        | SERIAL_ADDR_MATCH | SERIAL_BUS_TIMEOUT; // RULE1
    assign src.set_evt[`MFG_SRC_LOWV]   = lv_rise;           // RULE4
    assign src.set_evt[`MFG_SRC_EEPROM] = EEPROM_WRITE_DONE; // RULE6
    assign en_vec[`MFG_SRC_SERIAL] = SERIAL_MODULE_ENABLE;
    assign en_vec[`MFG_SRC_LOWV]   = LOW_VOLTAGE_ENABLE;
    assign en_vec[`MFG_SRC_EEPROM] = EEPROM_WRITE_ENABLE;

    genvar t;
    generate
        for (t = 0; t < NTM; t++) begin : g_timer
            localparam int A = `MFG_SRC_TIMER_BASE + 2 * t;
            assign src.set_evt[A]     = TIMER_MATCH_A[t]; // RULE8
            assign src.set_evt[A + 1] = TIMER_MATCH_P[t]; // RULE8
            assign en_vec[A]          = TIMER_ENABLE_A[t];
            assign en_vec[A + 1]      = TIMER_ENABLE_P[t];
        end
    endgenerate

    assign src.sw_set = FLAG_SET;
    assign src.sw_clr = FLAG_CLEAR;

    mfg_source_flags #(.N(NSRC)) u_flags (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .src   (src.store)
    );

    // =================================================================
    // group flags: an enabled member request that newly appears sets it
    assign pend      = src.flag & en_vec;
    assign pend_rise = pend & ~pend_q_r;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_q_r <= '0;
        end else begin
            pend_q_r <= pend;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NG; g++) begin : g_group
            always_comb begin
                group_set[g] = 1'h0;
                for (int s = 0; s < NSRC; s++) begin
                    if (in_group(s, g) && pend_rise[s]) begin
                        group_set[g] = 1'h1; // RULE18
                    end
                end
            end
            // a new member request wins over the service clear
            always_ff @(posedge REF_CLK or negedge RST_N) begin
                if (!RST_N) begin
                    group_flag_r[g] <= `MFG_FLAG_RESET;
                end else if (group_set[g]) begin
                    group_flag_r[g] <= 1'h1;
                end else if (call_r && group_r == grp_t'(g)) begin
                    group_flag_r[g] <= 1'h0; // RULE3 RULE5 RULE7 RULE10
                end
            end
            assign group_req[g] = group_flag_r[g] & GROUP_ENABLE[g];
        end
    endgenerate

    // =================================================================
    // vector call sequencing
    assign req_any = (|group_req) & gie_r & ~STACK_FULL; // RULE2 RULE9

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_RUN;
            call_r  <= 1'h0;
            group_r <= grp_t'(0);
        end else begin
            call_r <= 1'h0;
            case (state_r)
                ST_RUN: begin
                    if (req_any) begin
                        call_r  <= 1'h1; // RULE15
                        group_r <= pick(group_req);
                        state_r <= ST_CALL;
                    end
                end
                ST_CALL: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // global enable: entry clear beats every set source
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gie_r <= `MFG_GIE_RESET;
        end else if (state_r == ST_RUN && req_any) begin
            gie_r <= 1'h0; // RULE3 RULE5 RULE7 RULE10
        end else if (INTERRUPT_EXIT || GLOBAL_ENABLE_SET) begin
            gie_r <= 1'h1; // RULE16
        end else if (GLOBAL_ENABLE_CLEAR) begin
            gie_r <= 1'h0;
        end
    end

    // subroutine exit pops without touching the global enable
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pop_r <= 1'h0;
        end else begin
            pop_r <= INTERRUPT_EXIT | SUBROUTINE_EXIT; // RULE16 RULE17
        end
    end

    // =================================================================
    // wake-up: flags are clocked, so a stopped oscillator must be
    // bridged by the clock controller outside this block
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wake_r <= 1'h0;
        end else begin
            wake_r <= |src.rise; // RULE11 RULE12
        end
    end

    assign VECTOR_CALL       = call_r;
    assign VECTOR_GROUP      = group_r;
    assign PC_PUSH           = call_r; // RULE15
    assign PC_POP            = pop_r;
    assign GLOBAL_IRQ_ENABLE = gie_r;
    assign SOURCE_FLAGS      = src.flag;
    assign GROUP_FLAGS       = group_flag_r;
    assign WAKEUP            = wake_r;

    // =================================================================
    // checks
    sequence s_request_seen;
        state_r == ST_RUN && req_any;
    endsequence

    sequence s_call_issued;
        VECTOR_CALL && !GLOBAL_IRQ_ENABLE;
    endsequence

    a_call_on_request: assert property ( // RULE2
        @(posedge REF_CLK) disable iff (!RST_N)
        s_request_seen |=> s_call_issued)
        else $error("request not turned into a vector call");
    a_call_gated: assert property ( // RULE9
        @(posedge REF_CLK) disable iff (!RST_N)
        VECTOR_CALL |-> $past(gie_r) && !$past(STACK_FULL)
                        && $past(GROUP_ENABLE[pick(group_req)]))
        else $error("vector call without enables or with full stack");
    a_group_cleared: assert property ( // RULE10
        @(posedge REF_CLK) disable iff (!RST_N)
        VECTOR_CALL && !group_set[VECTOR_GROUP]
        |=> !group_flag_r[$past(VECTOR_GROUP)])
        else $error("serviced group flag not cleared");
    a_source_kept: assert property ( // RULE3
        @(posedge REF_CLK) disable iff (!RST_N)
        VECTOR_CALL && !(|FLAG_CLEAR)
        |=> (src.flag & $past(src.flag)) == $past(src.flag))
        else $error("service altered a source flag");
    a_exit_sets_gie: assert property ( // RULE16
        @(posedge REF_CLK) disable iff (!RST_N)
        INTERRUPT_EXIT && !(state_r == ST_RUN && req_any)
        |=> GLOBAL_IRQ_ENABLE && PC_POP)
        else $error("interrupt exit did not restore global enable");
    a_ret_keeps_gie: assert property ( // RULE17
        @(posedge REF_CLK) disable iff (!RST_N)
        SUBROUTINE_EXIT && !INTERRUPT_EXIT && !GLOBAL_ENABLE_SET
        && !GLOBAL_IRQ_ENABLE |=> !GLOBAL_IRQ_ENABLE && PC_POP)
        else $error("subroutine exit changed global enable");
    a_wake_on_rise: assert property ( // RULE12
        @(posedge REF_CLK) disable iff (!RST_N)
        (|src.rise) |=> WAKEUP ##1 (WAKEUP == $past(|src.rise)))
        else $error("flag rise did not raise wake-up");
    a_group_follows: assert property ( // RULE18
        @(posedge REF_CLK) disable iff (!RST_N)
        (|group_set) |=> ((GROUP_FLAGS & $past(group_set))
                          == $past(group_set)))
        else $error("group flag missed a member request");
    a_lowv_sync: assert property ( // RULE4
        @(posedge REF_CLK) disable iff (!RST_N)
        lv_rise |=> src.flag[`MFG_SRC_LOWV])
        else $error("low supply did not set its flag");
endmodule

//--- core_model.sv
// processor core model: stack depth and return instructions
`timescale 1ns/1ns
module core_model #(
    parameter int DEPTH = 1,
    parameter int DELAY = 2
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic push,
    input  wire logic pop,
    output wire logic stack_full,
    output logic      intr_exit,
    output logic      sub_exit
);
    int depth_r;

    // =================================================================
    // stack
    // only the program counter goes on the stack, so a depth is enough
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            depth_r <= 0;
        end else begin
            depth_r <= depth_r + int'(push) - int'(pop);
        end
    end
    // a full stack must hold off every vector call
    assign stack_full = (depth_r >= DEPTH);

    // =================================================================
    // returns
    // a slow core waits DELAY cycles; the pulse moves off the clock edge
    task automatic issue_return(input logic intr);
        repeat (DELAY) @(negedge clk);
        intr_exit = intr;
        sub_exit = !intr;
        @(negedge clk);
        intr_exit = 1'h0;
        sub_exit = 1'h0;
    endtask

    initial begin
        intr_exit = 1'h0;
        sub_exit = 1'h0;
    end
endmodule

//--- multifunction_interrupt_group_tb.sv
// self-checking bench for the multi-function interrupt group
`timescale 1ns/1ns
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin \
    err_total++; $display("Error at %0t: got %0h expected %0h", \
    $time, act, exp); end end
module multifunction_interrupt_group_tb import mfg_pkg::*;;
    localparam logic [17:0] MAP = 18'h2_943F;
    logic       clk;
    logic       rst_n;
    logic       byte_done, addr_match, bus_timeout, lv_detect, ee_done;
    logic [2:0] tm_a, tm_p;
    logic [8:0] flag_set, flag_clr, src_en, src_flags;
    logic [3:0] grp_en, grp_flags;
    logic       gie_set, gie_clr, stack_full, intr_exit, sub_exit;
    logic       vector_call, pc_push, pc_pop, gie, wakeup;
    grp_t       vector_group, last_grp, g;
    int         err_total, check_count, wake_cnt, call_cnt, pop_cnt;
    int         k, s, w, p;

    multifunction_interrupt_group dut (
        .REF_CLK(clk), .RST_N(rst_n), .SERIAL_BYTE_DONE(byte_done),
        .SERIAL_ADDR_MATCH(addr_match), .SERIAL_BUS_TIMEOUT(bus_timeout),
        .LOW_VOLTAGE_DETECT(lv_detect), .EEPROM_WRITE_DONE(ee_done),
        .TIMER_MATCH_A(tm_a), .TIMER_MATCH_P(tm_p), .FLAG_SET(flag_set),
        .FLAG_CLEAR(flag_clr), .SERIAL_MODULE_ENABLE(src_en[0]),
        .LOW_VOLTAGE_ENABLE(src_en[1]), .EEPROM_WRITE_ENABLE(src_en[2]),
        .TIMER_ENABLE_A({src_en[7], src_en[5], src_en[3]}),
        .TIMER_ENABLE_P({src_en[8], src_en[6], src_en[4]}),
        .GROUP_ENABLE(grp_en), .GLOBAL_ENABLE_SET(gie_set),
        .GLOBAL_ENABLE_CLEAR(gie_clr), .STACK_FULL(stack_full),
        .INTERRUPT_EXIT(intr_exit), .SUBROUTINE_EXIT(sub_exit),
        .VECTOR_CALL(vector_call), .VECTOR_GROUP(vector_group),
        .PC_PUSH(pc_push), .PC_POP(pc_pop), .GLOBAL_IRQ_ENABLE(gie),
        .SOURCE_FLAGS(src_flags), .GROUP_FLAGS(grp_flags), .WAKEUP(wakeup)
    );
    core_model #(.DEPTH(1), .DELAY(2)) core (
        .clk(clk), .rst_n(rst_n), .push(pc_push), .pop(pc_pop),
        .stack_full(stack_full), .intr_exit(intr_exit), .sub_exit(sub_exit)
    );

    // =================================================================
    // clock and watchers
    initial begin
        clk = 1'h0;
        forever #2 clk = !clk;
    end
    always @(posedge clk) begin
        if (rst_n) begin
            wake_cnt += int'(wakeup);
            pop_cnt += int'(pc_pop);
            `CHK(pc_push, vector_call)
            if (vector_call === 1'h1) begin
                call_cnt++;
                last_grp = vector_group;
            end
        end
    end
    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    // =================================================================
    // tasks
    task automatic complete_run();
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // k: 0-2 serial causes, 3 low supply, 4 eeprom, 5-7 match A, 8-10 P
    function automatic int src_of(input int k);
        if (k < 5) return (k < 3) ? 0 : k - 2;
        return (k < 8) ? 3 + 2 * (k - 5) : 4 + 2 * (k - 8);
    endfunction
    task automatic fire(input int k);
        @(negedge clk);
        case (k)
            0: byte_done = 1'h1;
            1: addr_match = 1'h1;
            2: bus_timeout = 1'h1;
            3: lv_detect = 1'h1;
            4: ee_done = 1'h1;
            default: if (k < 8) tm_a[k-5] = 1'h1; else tm_p[k-8] = 1'h1;
        endcase
        // the detector level passes a synchroniser, so hold it longer
        repeat ((k == 3) ? 5 : 1) @(negedge clk);
        {byte_done, addr_match, bus_timeout, lv_detect, ee_done} = '0;
        tm_a = '0;
        tm_p = '0;
    endtask
    task automatic clr_all();
        @(negedge clk);
        flag_clr = '1;
        @(negedge clk);
        flag_clr = '0;
    endtask
    task automatic set_gie(input logic on);
        @(negedge clk);
        gie_set = on;
        gie_clr = !on;
        @(negedge clk);
        {gie_set, gie_clr} = '0;
    endtask
    task automatic no_call(input int n);
        int c0;
        c0 = call_cnt;
        repeat (n) @(negedge clk);
        `CHK(call_cnt, c0)
    endtask
    task automatic expect_call(input grp_t eg);
        int c0;
        int n;
        c0 = call_cnt;
        n = 0;
        while (call_cnt == c0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (call_cnt == c0) begin
            err_total++;
            $display("Error at %0t: no vector call", $time);
            complete_run();
        end
        `CHK(last_grp, eg)
    endtask

    // =================================================================
    // main sequence
    initial begin
        {byte_done, addr_match, bus_timeout, lv_detect, ee_done} = '0;
        {tm_a, tm_p, flag_set, flag_clr, src_en, grp_en} = '0;
        {gie_set, gie_clr} = '0;
        rst_n = 1'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'h1;
        `CHK({gie, vector_call, wakeup}, 3'h0)
        `CHK({src_flags, grp_flags}, 13'h0000)
        // every source with all enables off: flag, wake, no service
        for (k = 0; k < 11; k++) begin
            s = src_of(k);
            w = wake_cnt;
            fire(k);
            repeat (6) @(negedge clk);
            `CHK(src_flags[s], 1'h1)
            `CHK(wake_cnt, w + 1)
            fire(k);
            repeat (6) @(negedge clk);
            `CHK(wake_cnt, w + 1)
            `CHK(src_flags[s], 1'h1)
            `CHK(grp_flags, 4'h0)
            `CHK(call_cnt, 0)
            clr_all();
        end
        // service each of the 11 source causes once, alternating the two returns
        grp_en = 4'hF;
        for (k = 0; k < 11; k++) begin
            s = src_of(k);
            g = grp_t'(MAP >> (2 * s));
            p = pop_cnt;
            set_gie(1'h1);
            src_en = 9'h001 << s;
            fire(k);
            expect_call(g);
            repeat (2) @(negedge clk);
            `CHK(gie, 1'h0)
            `CHK(grp_flags[g], 1'h0)
            `CHK(src_flags[s], 1'h1)
            core.issue_return(k[0]);
            @(negedge clk);
            `CHK(pop_cnt, p + 1)
            `CHK(gie, k[0])
            src_en = '0;
            clr_all();
        end
        // refusals: group enable off, global enable off, stack full
        src_en = 9'h008;
        grp_en = 4'h0;
        set_gie(1'h1);
        fire(5);
        no_call(8);
        `CHK(grp_flags[0], 1'h1)
        set_gie(1'h0);
        grp_en = 4'hF;
        no_call(8);
        set_gie(1'h1);
        expect_call(2'h0);
        src_en = 9'h028;
        fire(6);
        set_gie(1'h1);
        no_call(8);
        `CHK(src_flags[5], 1'h1)
        core.issue_return(1'h1);
        expect_call(2'h1);
        core.issue_return(1'h1);
        // two groups pending at once: the lowest number is called first
        src_en = '0;
        clr_all();
        set_gie(1'h0);
        src_en = 9'h088;
        fire(7);
        fire(5);
        set_gie(1'h1);
        expect_call(2'h0);
        core.issue_return(1'h1);
        expect_call(2'h2);
        core.issue_return(1'h1);
        // a flag set by software first mutes the wake of its source
        src_en = '0;
        clr_all();
        w = wake_cnt;
        @(negedge clk);
        flag_set[2] = 1'h1;
        @(negedge clk);
        flag_set[2] = 1'h0;
        repeat (4) @(negedge clk);
        `CHK(wake_cnt, w + 1)
        fire(4);
        repeat (6) @(negedge clk);
        `CHK(wake_cnt, w + 1)
        complete_run();
    end
endmodule
